//--- pkg/gpcn_pkg.sv
package gpcn_pkg;
  // Register byte offsets (word aligned); base, clear, set, toggle
  localparam logic [7:0] ANSEL_OFS   = 8'h00;
  localparam logic [7:0] DIR_OFS     = 8'h10;
  localparam logic [7:0] PIN_OFS     = 8'h20;
  localparam logic [7:0] LAT_OFS     = 8'h30;
  localparam logic [7:0] ODC_OFS     = 8'h40;
  localparam logic [7:0] CNCON_OFS   = 8'h50;
  localparam logic [7:0] CNEN_OFS    = 8'h60;
  localparam logic [7:0] CNSTAT_OFS  = 8'h70;
  localparam logic [7:0] PU_OFS      = 8'h80;
  localparam logic [7:0] PD_OFS      = 8'h90;
  localparam logic [7:0] REMAP_OFS   = 8'hA0;
  localparam logic [7:0] PERIPH_OFS  = 8'hB0;
  localparam logic [7:0] LAST_OFS    = 8'hBC;
  localparam logic [1:0] ALIAS_BASE  = 2'h0;
  localparam logic [1:0] ALIAS_CLR   = 2'h1;
  localparam logic [1:0] ALIAS_SET   = 2'h2;
  localparam logic [1:0] ALIAS_INV   = 2'h3;
  localparam int         CNCON_ON_BIT = 15;
  localparam logic [31:0] ANSEL_RST  = 32'h0000_FFFF;
  localparam logic [31:0] DIR_RST    = 32'hFFFF_FFFF;
  localparam logic [31:0] ZERO_RST   = 32'h0000_0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

//--- hw/gpcn_port.sv
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module gpcn_port #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic [31:0]       hrdata,
  output logic              hreadyout,
  output logic              hresp,
  input  wire logic [W-1:0] pin_in,
  output logic [W-1:0]      pin_out,
  output logic [W-1:0]      pin_oe_n,
  output logic [W-1:0]      pullup_en,
  output logic [W-1:0]      pulldown_en,
  output logic [W-1:0]      analog_en,
  input  wire logic [W-1:0] remap_out,
  input  wire logic [W-1:0] remap_oe,
  input  wire logic [W-1:0] periph_out,
  input  wire logic [W-1:0] periph_oe,
  input  wire logic [W-1:0] sleep_change,
  output logic              change_irq
);
  localparam logic [W-1:0] ANS_RST = W'(gpcn_pkg::ANSEL_RST);
  localparam logic [W-1:0] DIR_RST = W'(gpcn_pkg::DIR_RST);
  localparam logic [W-1:0] ZRST    = W'(gpcn_pkg::ZERO_RST);

  logic [W-1:0] analog_select_q, analog_select_d;
  logic [W-1:0] direction_ctrl_q, direction_ctrl_d;
  logic [W-1:0] output_latch_q, output_latch_d;
  logic [W-1:0] open_drain_ctrl_q, open_drain_ctrl_d;
  logic [W-1:0] change_irq_enable_q, change_irq_enable_d;
  logic [W-1:0] change_status_q, change_status_d;
  logic [W-1:0] pullup_enable_q, pullup_enable_d;
  logic [W-1:0] pulldown_enable_q, pulldown_enable_d;
  logic [W-1:0] remap_assign_q, remap_assign_d;
  logic [W-1:0] periph_active_q, periph_active_d;
  logic         cn_on_q, cn_on_d;
  logic [W-1:0] sync1_q, sync2_q, ref_q, ref_d;
  logic [W-1:0] sleep1_q, sleep2_q;
  logic         wr_q, wr_d;
  logic [7:0]   addr_q, addr_d;
  logic [31:0]  hrdata_d;
  logic [W-1:0] pin_view, pin_out_d, oe_n_d;
  logic         irq_d;
  logic         rd_pin;

  // Applies base, clear, set or toggle to a register
  function automatic logic [W-1:0] alias_op(input logic [W-1:0] cur,
                                            input logic [W-1:0] wd,
                                            input logic [1:0]   sel);
    case (sel)
      gpcn_pkg::ALIAS_CLR: alias_op = cur & ~wd;
      gpcn_pkg::ALIAS_SET: alias_op = cur | wd;
      gpcn_pkg::ALIAS_INV: alias_op = cur ^ wd;
      default:             alias_op = wd;
    endcase
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
    hit = (a[7:4] == base[7:4]);
  endfunction

  // Analog input pins read as zero
  assign pin_view = sync2_q & ~(analog_select_q & direction_ctrl_q);

  // Bus address phase capture; the slave never waits
  always_comb begin
    wr_d   = 1'b0;
    addr_d = addr_q;
    rd_pin = 1'b0;
    if (hsel && hready && htrans == gpcn_pkg::HTRANS_NONSEQ) begin
      wr_d   = hwrite;
      addr_d = haddr[7:0];
      rd_pin = !hwrite && hit(haddr[7:0], gpcn_pkg::PIN_OFS)
               && haddr[3:2] == gpcn_pkg::ALIAS_BASE;
    end
  end

  always_comb begin
    hrdata_d = 32'h0000_0000;
    if (hsel && hready && htrans == gpcn_pkg::HTRANS_NONSEQ && !hwrite
        && haddr[3:2] == gpcn_pkg::ALIAS_BASE) begin
      case (haddr[7:4])
        gpcn_pkg::ANSEL_OFS[7:4]:  hrdata_d[W-1:0] = analog_select_q;
        gpcn_pkg::DIR_OFS[7:4]:    hrdata_d[W-1:0] = direction_ctrl_q;
        gpcn_pkg::PIN_OFS[7:4]:    hrdata_d[W-1:0] = pin_view;
        gpcn_pkg::LAT_OFS[7:4]:    hrdata_d[W-1:0] = output_latch_q;
        gpcn_pkg::ODC_OFS[7:4]:    hrdata_d[W-1:0] = open_drain_ctrl_q;
        gpcn_pkg::CNCON_OFS[7:4]:  hrdata_d[gpcn_pkg::CNCON_ON_BIT] = cn_on_q;
        gpcn_pkg::CNEN_OFS[7:4]:   hrdata_d[W-1:0] = change_irq_enable_q;
        gpcn_pkg::CNSTAT_OFS[7:4]: hrdata_d[W-1:0] = change_status_q;
        gpcn_pkg::PU_OFS[7:4]:     hrdata_d[W-1:0] = pullup_enable_q;
        gpcn_pkg::PD_OFS[7:4]:     hrdata_d[W-1:0] = pulldown_enable_q;
        gpcn_pkg::REMAP_OFS[7:4]:  hrdata_d[W-1:0] = remap_assign_q;
        gpcn_pkg::PERIPH_OFS[7:4]: hrdata_d[W-1:0] = periph_active_q;
        default:                   hrdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Register writes in the data phase
  always_comb begin
    analog_select_d     = analog_select_q;
    direction_ctrl_d    = direction_ctrl_q;
    output_latch_d      = output_latch_q;
    open_drain_ctrl_d   = open_drain_ctrl_q;
    change_irq_enable_d = change_irq_enable_q;
    pullup_enable_d     = pullup_enable_q;
    pulldown_enable_d   = pulldown_enable_q;
    remap_assign_d      = remap_assign_q;
    periph_active_d     = periph_active_q;
    cn_on_d             = cn_on_q;
    if (wr_q) begin
      case (addr_q[7:4])
        gpcn_pkg::ANSEL_OFS[7:4]: analog_select_d =
          alias_op(analog_select_q, hwdata[W-1:0], addr_q[3:2]);
        gpcn_pkg::DIR_OFS[7:4]: direction_ctrl_d =
          alias_op(direction_ctrl_q, hwdata[W-1:0], addr_q[3:2]);
        gpcn_pkg::PIN_OFS[7:4], gpcn_pkg::LAT_OFS[7:4]: output_latch_d =
          alias_op(output_latch_q, hwdata[W-1:0], addr_q[3:2]);
        gpcn_pkg::ODC_OFS[7:4]: open_drain_ctrl_d =
          alias_op(open_drain_ctrl_q, hwdata[W-1:0], addr_q[3:2]);
        gpcn_pkg::CNCON_OFS[7:4]: cn_on_d =
          alias_op({{(W-1){1'b0}}, cn_on_q},
                   {{(W-1){1'b0}}, hwdata[gpcn_pkg::CNCON_ON_BIT]},
                   addr_q[3:2]) != '0;
        gpcn_pkg::CNEN_OFS[7:4]: change_irq_enable_d =
          alias_op(change_irq_enable_q, hwdata[W-1:0], addr_q[3:2]);
        gpcn_pkg::PU_OFS[7:4]: pullup_enable_d =
          alias_op(pullup_enable_q, hwdata[W-1:0], addr_q[3:2]);
        gpcn_pkg::PD_OFS[7:4]: pulldown_enable_d =
          alias_op(pulldown_enable_q, hwdata[W-1:0], addr_q[3:2]);
        gpcn_pkg::REMAP_OFS[7:4]: remap_assign_d =
          alias_op(remap_assign_q, hwdata[W-1:0], addr_q[3:2]);
        gpcn_pkg::PERIPH_OFS[7:4]: periph_active_d =
          alias_op(periph_active_q, hwdata[W-1:0], addr_q[3:2]);
        default: cn_on_d = cn_on_q;
      endcase
    end
  end

  // Change detection; a sleep-change set wins over clear-by-read, a pin change in the read cycle is lost
  always_comb begin
    ref_d           = ref_q;
    change_status_d = change_status_q;
    if (rd_pin) begin
      ref_d           = pin_view;
      change_status_d = '0;
    end
    if (cn_on_q) begin
      // Compare with the reference after any read, so a read can clear
      change_status_d = change_status_d
        | ((pin_view ^ ref_d) | sleep2_q) & change_irq_enable_q;
    end
    irq_d = |(change_status_q & change_irq_enable_q);
  end

  // Pad drive priority: analog select (latch path), remap, fixed peripheral, latch
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (remap_assign_q[i] && !analog_select_q[i]) begin
        pin_out_d[i] = remap_out[i];
        oe_n_d[i]    = !remap_oe[i];
      end else if (periph_active_q[i] && !analog_select_q[i]) begin
        pin_out_d[i] = periph_out[i];
        oe_n_d[i]    = !periph_oe[i];
      end else begin
        pin_out_d[i] = output_latch_q[i];
        oe_n_d[i]    = direction_ctrl_q[i];
      end
      if (open_drain_ctrl_q[i]) begin
        oe_n_d[i]    = oe_n_d[i] | pin_out_d[i];
        pin_out_d[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      analog_select_q     <= ANS_RST;
      direction_ctrl_q    <= DIR_RST;
      output_latch_q      <= ZRST;
      open_drain_ctrl_q   <= ZRST;
      change_irq_enable_q <= ZRST;
      change_status_q     <= ZRST;
      pullup_enable_q     <= ZRST;
      pulldown_enable_q   <= ZRST;
      remap_assign_q      <= ZRST;
      periph_active_q     <= ZRST;
      cn_on_q             <= 1'b0;
      sync1_q             <= ZRST;
      sync2_q             <= ZRST;
      sleep1_q            <= ZRST;
      sleep2_q            <= ZRST;
      ref_q               <= ZRST;
      wr_q                <= 1'b0;
      addr_q              <= 8'h00;
      hrdata              <= 32'h0000_0000;
      pin_out             <= ZRST;
      pin_oe_n            <= DIR_RST;
      pullup_en           <= ZRST;
      pulldown_en         <= ZRST;
      analog_en           <= ANS_RST;
      change_irq          <= 1'b0;
    end else begin
      analog_select_q     <= analog_select_d;
      direction_ctrl_q    <= direction_ctrl_d;
      output_latch_q      <= output_latch_d;
      open_drain_ctrl_q   <= open_drain_ctrl_d;
      change_irq_enable_q <= change_irq_enable_d;
      change_status_q     <= change_status_d;
      pullup_enable_q     <= pullup_enable_d;
      pulldown_enable_q   <= pulldown_enable_d;
      remap_assign_q      <= remap_assign_d;
      periph_active_q     <= periph_active_d;
      cn_on_q             <= cn_on_d;
      sync1_q             <= pin_in;
      sync2_q             <= sync1_q;
      // Sleep latch is asynchronous outside; resampled here
      sleep1_q            <= sleep_change;
      sleep2_q            <= sleep1_q;
      ref_q               <= ref_d;
      wr_q                <= wr_d;
      addr_q              <= addr_d;
      hrdata              <= hrdata_d;
      pin_out             <= pin_out_d;
      pin_oe_n            <= oe_n_d;
      pullup_en           <= pullup_enable_q;
      pulldown_en         <= pulldown_enable_q;
      analog_en           <= analog_select_q & direction_ctrl_q;
      change_irq          <= irq_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  property p_ansel_reset;
    @(posedge clk) $fell(srst) |-> analog_select_q == ANS_RST;
  endproperty
  a_ansel_reset: assert property (p_ansel_reset) else $error("ansel rst");
  property p_dir_reset;
    @(posedge clk) $fell(srst) |-> pin_oe_n == DIR_RST;
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("dir rst");
  property p_analog_zero;
    @(posedge clk) disable iff (srst)
      (hsel && hready && htrans == gpcn_pkg::HTRANS_NONSEQ && !hwrite
       && haddr[7:0] == gpcn_pkg::PIN_OFS)
      |=> (hrdata[W-1:0] & $past(analog_select_q & direction_ctrl_q)) == '0;
  endproperty
  a_analog_zero: assert property (p_analog_zero) else $error("analog");
  property p_irq;
    @(posedge clk) disable iff (srst)
      |(change_status_q & change_irq_enable_q) |=> change_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_status_set;
    @(posedge clk) disable iff (srst)
      (cn_on_q && !rd_pin && |((pin_view ^ ref_q) & change_irq_enable_q))
      |=> |change_status_q;
  endproperty
  a_status_set: assert property (p_status_set) else $error("stat");
  property p_set_alias;
    @(posedge clk) disable iff (srst)
      (wr_q && addr_q == (gpcn_pkg::LAT_OFS | 8'h08))
      |=> output_latch_q == ($past(output_latch_q) | $past(hwdata[W-1:0]));
  endproperty
  a_set_alias: assert property (p_set_alias) else $error("set");
  property p_clr_alias;
    @(posedge clk) disable iff (srst)
      (wr_q && addr_q == (gpcn_pkg::DIR_OFS | 8'h04))
      |=> direction_ctrl_q ==
          ($past(direction_ctrl_q) & ~$past(hwdata[W-1:0]));
  endproperty
  a_clr_alias: assert property (p_clr_alias) else $error("clr");
  property p_pull;
    @(posedge clk) disable iff (srst)
      ##1 pullup_en == $past(pullup_enable_q);
  endproperty
  a_pull: assert property (p_pull) else $error("pull");
  property p_od;
    @(posedge clk) disable iff (srst)
      1'b1 |=> (pin_out & $past(open_drain_ctrl_q)) == '0;
  endproperty
  a_od: assert property (p_od) else $error("od");
  c_irq:  cover property (@(posedge clk) $rose(change_irq));
  c_inv:  cover property (@(posedge clk)
            wr_q && addr_q[3:2] == gpcn_pkg::ALIAS_INV);
  c_pinrd: cover property (@(posedge clk) rd_pin && |change_status_q);
endmodule // gpcn_port

//--- tb/gpcn_pad_model.sv
`timescale 1ns/10ps
module gpcn_pad_model #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] pin_out,
  input  wire logic [W-1:0] pin_oe_n,
  input  wire logic [W-1:0] pullup_en,
  input  wire logic [W-1:0] pulldown_en,
  input  wire logic [W-1:0] ext_en,
  input  wire logic [W-1:0] ext_val,
  output logic [W-1:0]      pin_in
);
  // Undriven pads with no pull flip each cycle so no read can lean on them
  logic [W-1:0] float_q = '0;
  logic [W-1:0] float_d;
  always_comb begin
    float_d = ~float_q;
    for (int i = 0; i < W; i++) begin
      pin_in[i] = !pin_oe_n[i]   ? pin_out[i] :
                  ext_en[i]      ? ext_val[i] :
                  pullup_en[i]   ? 1'b1 :
                  pulldown_en[i] ? 1'b0 : float_q[i];
    end
  end
  always_ff @(posedge clk) begin
    float_q <= float_d;
  end
endmodule // gpcn_pad_model

//--- tb/gpio_port_change_notify_bench.sv
`timescale 1ns/10ps
module gpio_port_change_notify_bench;
  logic        clk;
  logic        srst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic        change_irq;
  logic [15:0] pin_in, pin_out, pin_oe_n, pullup_en, pulldown_en, analog_en;
  logic [15:0] remap_out, remap_oe, periph_out, periph_oe, sleep_change;
  logic [15:0] ext_en, ext_val;
  logic [31:0] rv;
  int          bad_count;
  int          cmp_count;

  assign hready = hreadyout;

  gpcn_port #(.W(16)) dut (
    .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pullup_en(pullup_en), .pulldown_en(pulldown_en),
    .analog_en(analog_en), .remap_out(remap_out), .remap_oe(remap_oe),
    .periph_out(periph_out), .periph_oe(periph_oe),
    .sleep_change(sleep_change), .change_irq(change_irq)
  );

  gpcn_pad_model #(.W(16)) pads (
    .clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pullup_en(pullup_en), .pulldown_en(pulldown_en), .ext_en(ext_en),
    .ext_val(ext_val), .pin_in(pin_in)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Ready is taken at the rising edge that ends each phase, read data at the one that ends the data phase
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= gpcn_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0000_0000, x);
    chk(n, e, x);
    chk("hresp", 32'h0000_0000, {31'h0, hresp});
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("[ERR] watchdog expected end seen hang");
    give_verdict();
  end

  initial begin
    {srst, hsel, hwrite} = 3'b100;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
    {remap_out, remap_oe, periph_out, periph_oe, sleep_change} = '0;
    ext_en  = 16'hFFFF;
    ext_val = 16'hFFFF;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("analog_en", 32'h0000_FFFF, {16'h0000, analog_en});
    chk("pin_oe_n", 32'h0000_FFFF, {16'h0000, pin_oe_n});
    rchk("ansel", gpcn_pkg::ANSEL_OFS, 32'h0000_FFFF);
    rchk("dir", gpcn_pkg::DIR_OFS, 32'h0000_FFFF);
    rchk("pin", gpcn_pkg::PIN_OFS, 32'h0000_0000);
    rchk("unmapped", 8'hC0, 32'h0000_0000);
    $display("reset test done");
    wr(gpcn_pkg::LAT_OFS, 32'h0000_00F0);
    wr(gpcn_pkg::LAT_OFS + 8'h08, 32'h0000_000F);
    rchk("lat_set", gpcn_pkg::LAT_OFS, 32'h0000_00FF);
    wr(gpcn_pkg::LAT_OFS + 8'h04, 32'h0000_0030);
    rchk("lat_clr", gpcn_pkg::LAT_OFS, 32'h0000_00CF);
    wr(gpcn_pkg::LAT_OFS + 8'h0C, 32'h0000_0101);
    rchk("lat_inv", gpcn_pkg::LAT_OFS, 32'h0000_01CE);
    rchk("alias_rd", gpcn_pkg::LAT_OFS + 8'h08, 32'h0000_0000);
    wr(gpcn_pkg::PIN_OFS, 32'h0000_0155);
    rchk("lat_via_pin", gpcn_pkg::LAT_OFS, 32'h0000_0155);
    wr(gpcn_pkg::ANSEL_OFS + 8'h04, 32'h0000_00FF);
    rchk("ansel_clr", gpcn_pkg::ANSEL_OFS, 32'h0000_FF00);
    $display("alias test done");
    wr(gpcn_pkg::DIR_OFS + 8'h04, 32'h0000_01FF);
    repeat (4) @(posedge clk);
    chk("oe_n", 32'h0000_FE00, {16'h0000, pin_oe_n});
    chk("out", 32'h0000_0155, {16'h0000, pin_out & 16'h01FF});
    chk("analog", 32'h0000_FE00, {16'h0000, analog_en});
    rchk("pin_mix", gpcn_pkg::PIN_OFS, 32'h0000_0155);
    // Pulls set on input pins 12 to 15 only; the port does not gate pulls by direction
    wr(gpcn_pkg::PU_OFS, 32'h0000_3000);
    wr(gpcn_pkg::PD_OFS, 32'h0000_C000);
    repeat (3) @(posedge clk);
    chk("pulls", 32'h3000_C000, {pullup_en, pulldown_en});
    wr(gpcn_pkg::ODC_OFS, 32'h0000_0001);
    repeat (4) @(posedge clk);
    chk("od_high", 32'h0000_0002, {30'h0, pin_oe_n[0], pin_out[0]});
    wr(gpcn_pkg::LAT_OFS + 8'h04, 32'h0000_0001);
    repeat (4) @(posedge clk);
    chk("od_low", 32'h0000_0000, {30'h0, pin_oe_n[0], pin_out[0]});
    $display("output test done");
    remap_out <= 16'h0206;
    remap_oe  <= 16'h0206;
    periph_oe <= 16'h0004;
    repeat (4) @(posedge clk);
    chk("unassigned", 32'h0000_0002, {30'h0, pin_out[2:1]});
    wr(gpcn_pkg::PERIPH_OFS, 32'h0000_0004);
    repeat (4) @(posedge clk);
    chk("fixed", 32'h0000_0000, {30'h0, pin_out[2:1]});
    wr(gpcn_pkg::REMAP_OFS, 32'h0000_0206);
    repeat (4) @(posedge clk);
    chk("remap", 32'h0000_0003, {30'h0, pin_out[2:1]});
    chk("analog_wins", 32'h0000_0003, {30'h0, pin_oe_n[9], analog_en[9]});
    $display("priority test done");
    wr(gpcn_pkg::ANSEL_OFS + 8'h04, 32'h0000_F000);
    wr(gpcn_pkg::CNCON_OFS, 32'h0000_8000);
    wr(gpcn_pkg::CNEN_OFS, 32'h0000_5000);
    ahb(1'b0, gpcn_pkg::PIN_OFS, 32'h0000_0000, rv);
    ext_val <= 16'hDFFF;
    repeat (6) @(posedge clk);
    chk("irq_masked", 32'h0000_0000, {31'h0, change_irq});
    ext_val <= 16'hCFFF;
    repeat (6) @(posedge clk);
    chk("irq_on", 32'h0000_0001, {31'h0, change_irq});
    ahb(1'b0, gpcn_pkg::CNSTAT_OFS, 32'h0000_0000, rv);
    chk("stat12", 32'h0000_1000, rv & 32'h0000_1000);
    ahb(1'b0, gpcn_pkg::PIN_OFS, 32'h0000_0000, rv);
    repeat (4) @(posedge clk);
    chk("irq_off", 32'h0000_0000, {31'h0, change_irq});
    rchk("stat_clr", gpcn_pkg::CNSTAT_OFS, 32'h0000_0000);
    sleep_change <= 16'h4000;
    repeat (4) @(posedge clk);
    sleep_change <= 16'h0000;
    repeat (4) @(posedge clk);
    chk("sleep_irq", 32'h0000_0001, {31'h0, change_irq});
    ahb(1'b0, gpcn_pkg::CNSTAT_OFS, 32'h0000_0000, rv);
    chk("stat14", 32'h0000_4000, rv & 32'h0000_4000);
    $display("change test done");
    give_verdict();
  end
endmodule // gpio_port_change_notify_bench
